// ===== pkg/ppu_cfg_pkg.sv
package ppu_cfg_pkg;
    // ------------------------------------------------------------
    // register map (word index == byte offset / 4 not used: plain port)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_SELECT = 4'h0;
    localparam logic [3:0] ADDR_INIT = 4'h1;
    localparam logic [3:0] ADDR_PROCESS = 4'h2;
    localparam logic [3:0] ADDR_PINSEL = 4'h3;
    localparam logic [3:0] ADDR_DIR = 4'h4;
    localparam logic [3:0] ADDR_OUT = 4'h5;
    localparam logic [3:0] ADDR_HIDDEN = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h7;
    localparam logic [3:0] ADDR_PINS = 4'h8;
    localparam logic [3:0] ADDR_UPDATE = 4'h9;
    localparam logic [3:0] ADDR_REGPOOL = 4'ha;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SEL_CARD_LSB = 0;
    localparam int SEL_DEV_LSB = 8;
    localparam int PS_OP_LSB = 0;
    localparam int PS_OPOL_BIT = 7;
    localparam int PS_IP_LSB = 8;
    localparam int PS_IEDG_LSB = 14;
    localparam int PS_TP_LSB = 16;
    localparam int PS_TEDG_LSB = 22;
    localparam int PS_GP_LSB = 24;
    localparam int PS_RUN_BIT = 31;
    // ------------------------------------------------------------
    // encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] DEV_LOWER = 2'h1;
    localparam logic [1:0] DEV_UPPER = 2'h2;
    localparam logic [1:0] EDGE_LOCK = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [5:0] MFNR_RESET = 6'h00;
    localparam logic [4:0] CARD_MAX = 5'h10;
    localparam logic [3:0] DIR_RESET = 4'h0;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int RESOL_STEP_PS = 250000;
    localparam int RESOL_STEP_CYC = (RESOL_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int INT_CLK_PS = 5000000;
    localparam int INT_HALF_CYC = INT_CLK_PS / 2 / CLK_PERIOD_PS;
    localparam int MFNR_FULL = 32;
    localparam int PROC_MAX = 16;
endpackage

// ===== rtl/pulse_processor_pin_config.sv
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/100ps
module pulse_processor_pin_config #(
    parameter logic [4:0] CARD_ID = 5'h01
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire logic [31:0] chan_in,
    output logic [31:0] chan_out,
    output logic [31:0] chan_oe,
    output logic [31:0] led_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] card;
        logic [1:0] dev;
        logic [1:0] [5:0] mfnr;
        logic run;
        logic fresh;
        logic [31:0] drive;
        logic [1:0] [31:0] procsel;
        logic [1:0] [3:0] dir;
        logic [31:0] outv;
        logic [15:0] hidden;
        logic [1:0] [15:0] regpool;
        logic [31:0] sync1;
        logic [31:0] sync2;
        logic [31:0] prev;
        logic [5:0] tick_cnt;
        logic [1:0] [4:0] slot_cnt;
        logic [1:0] tick;
        logic [9:0] int_cnt;
        logic int_clk;
        logic [1:0] hit;
        logic [31:0] rdata;
        logic [31:0] pins;
        logic [31:0] oe;
        logic [31:0] led;
    } state_t;

    state_t s_q, s_d;

    // ------------------------------------------------------------
    // decoding shared by input, trigger and gate selectors
    // ------------------------------------------------------------
    function automatic logic pick_in(input logic [5:0] sel, input logic [31:0] real_pins,
                                     input logic [15:0] hid, input logic ick);
        logic v;
        v = 1'b0;
        if (sel == 6'h00) begin
            v = ick;
        end else if (sel <= 6'h20) begin
            v = real_pins[5'(sel - 6'h01)];
        end else if (sel <= 6'h30) begin
            v = hid[4'(sel - 6'h21)];
        end
        return v;
    endfunction

    function automatic logic edge_hit(input logic [1:0] mode, input logic now, input logic was);
        logic v;
        v = 1'b0;
        case (mode)
            ppu_cfg_pkg::EDGE_RISE: v = now & ~was;
            ppu_cfg_pkg::EDGE_FALL: v = ~now & was;
            ppu_cfg_pkg::EDGE_BOTH: v = now ^ was;
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    function automatic logic [5:0] tbl_len(input logic [5:0] m);
        logic [5:0] v;
        v = (m == 6'h00) ? 6'(ppu_cfg_pkg::MFNR_FULL) : m;
        return v;
    endfunction

    // processes per pass, stepwise as tabulated
    function automatic logic [4:0] proc_count(input logic [5:0] m);
        logic [4:0] v;
        if (m == 6'h00 || m >= 6'h14) begin
            v = 5'(ppu_cfg_pkg::PROC_MAX);
        end else if (m <= 6'h01) begin
            v = 5'h00;
        end else if (m <= 6'h05) begin
            v = 5'(m - 6'h01);
        end else if (m <= 6'h0a) begin
            v = 5'(m - 6'h02);
        end else if (m <= 6'h0f) begin
            v = 5'(m - 6'h03);
        end else begin
            v = 5'(m - 6'h04);
        end
        return v;
    endfunction

    logic [31:0] real_now;
    logic board_sel;
    logic [1:0] dev_sel;
    logic [1:0] in_v, in_p, tr_v, tr_p, fire, trig;
    logic [6:0] op_idx [2];
    logic [15:0] hid_next;
    logic [31:0] out_next;
    logic [31:0] cfg_word;

    always_comb begin
        s_d = s_q;
        s_d.hit = 2'h0;
        real_now = s_q.pins;
        hid_next = s_q.hidden;
        out_next = s_q.outv;
        board_sel = (s_q.card != 5'h00) && (s_q.card == CARD_ID) &&
                    (s_q.card <= ppu_cfg_pkg::CARD_MAX);
        dev_sel[0] = board_sel && (s_q.dev == ppu_cfg_pkg::DEV_LOWER);
        dev_sel[1] = board_sel && (s_q.dev == ppu_cfg_pkg::DEV_UPPER);
        cfg_word = 32'h0;
        // two-stage synchroniser on field inputs
        s_d.sync1 = chan_in;
        s_d.sync2 = s_q.sync1;
        // ------------------------------------------------------------
        // time base: one slot per resolution step, pass per table
        // ------------------------------------------------------------
        s_d.tick = 2'h0;
        if (s_q.tick_cnt == 6'(ppu_cfg_pkg::RESOL_STEP_CYC - 1)) begin
            s_d.tick_cnt = 6'h00;
            // each controller walks its own table length
            for (int c = 0; c < 2; c++) begin
                if (s_q.slot_cnt[c] >= 5'(tbl_len(s_q.mfnr[c]) - 6'h01)) begin
                    s_d.slot_cnt[c] = 5'h00;
                    s_d.tick[c] = 1'b1;
                end else begin
                    s_d.slot_cnt[c] = s_q.slot_cnt[c] + 5'h01;
                end
            end
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 6'h01;
        end
        if (s_q.int_cnt == 10'(ppu_cfg_pkg::INT_HALF_CYC - 1)) begin
            s_d.int_cnt = 10'h000;
            s_d.int_clk = ~s_q.int_clk;
        end else begin
            s_d.int_cnt = s_q.int_cnt + 10'h001;
        end
        // ------------------------------------------------------------
        // per-controller process: sample only at pass boundary
        // ------------------------------------------------------------
        for (int c = 0; c < 2; c++) begin
            in_v[c] = pick_in(s_q.procsel[c][ppu_cfg_pkg::PS_IP_LSB +: 6], real_now,
                              s_q.hidden, s_q.int_clk);
            in_p[c] = s_q.prev[c];
            tr_v[c] = pick_in(s_q.procsel[c][ppu_cfg_pkg::PS_TP_LSB +: 6], real_now,
                              s_q.hidden, s_q.int_clk);
            tr_p[c] = s_q.prev[c+2];
            fire[c] = edge_hit(s_q.procsel[c][ppu_cfg_pkg::PS_IEDG_LSB +: 2], in_v[c], in_p[c]);
            trig[c] = edge_hit(s_q.procsel[c][ppu_cfg_pkg::PS_TEDG_LSB +: 2], tr_v[c], tr_p[c]);
            op_idx[c] = s_q.procsel[c][ppu_cfg_pkg::PS_OP_LSB +: 7];
            if (s_q.tick[c] && s_q.run && proc_count(s_q.mfnr[c]) != 5'h00) begin
                s_d.prev[c] = in_v[c];
                s_d.prev[c+2] = tr_v[c];
                if (trig[c]) begin
                    s_d.regpool[c] = 16'h0000;
                end else if (fire[c] && pick_in(s_q.procsel[c][ppu_cfg_pkg::PS_GP_LSB +: 6],
                             real_now, s_q.hidden, s_q.int_clk)) begin
                    s_d.regpool[c] = s_q.regpool[c] + 16'h0001;
                end
                if (fire[c]) begin
                    s_d.hit[c] = 1'b1;
                    if (op_idx[c] >= 7'h01 && op_idx[c] <= 7'h20) begin
                        out_next[5'(op_idx[c] - 7'h01)] =
                            ~s_q.outv[5'(op_idx[c] - 7'h01)];
                    end else if (op_idx[c] >= 7'h21 && op_idx[c] <= 7'h30) begin
                        hid_next[4'(op_idx[c] - 7'h21)] = ~s_q.hidden[4'(op_idx[c] - 7'h21)];
                    end
                end
            end
        end
        s_d.outv = out_next;
        s_d.hidden = hid_next;
        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (wr_stb) begin
            case (addr)
                ppu_cfg_pkg::ADDR_SELECT: begin
                    s_d.card = wdata[ppu_cfg_pkg::SEL_CARD_LSB +: 5];
                    s_d.dev = wdata[ppu_cfg_pkg::SEL_DEV_LSB +: 2];
                end
                ppu_cfg_pkg::ADDR_INIT: begin
                    for (int c = 0; c < 2; c++) begin
                        if (dev_sel[c]) begin
                            s_d.mfnr[c] = wdata[5:0];
                            s_d.run = 1'b0;
                            s_d.procsel[c] = '0;
                        end
                    end
                end
                ppu_cfg_pkg::ADDR_PROCESS: begin
                    for (int c = 0; c < 2; c++) begin
                        if (dev_sel[c]) begin
                            s_d.procsel[c] = wdata;
                            s_d.run = 1'b0;
                        end
                    end
                end
                ppu_cfg_pkg::ADDR_PINSEL: begin
                    s_d.run = board_sel ? wdata[0] : s_q.run;
                end
                ppu_cfg_pkg::ADDR_DIR: begin
                    if (board_sel) begin
                        s_d.dir[0] = wdata[3:0];
                        s_d.dir[1] = wdata[11:8];
                        // first direction write ends the forced low drive
                        s_d.fresh = 1'b0;
                    end
                end
                ppu_cfg_pkg::ADDR_OUT: s_d.outv = wdata;
                ppu_cfg_pkg::ADDR_HIDDEN: s_d.hidden = wdata[15:0];
                ppu_cfg_pkg::ADDR_UPDATE: begin
                    for (int c = 0; c < 2; c++) begin
                        if (dev_sel[c]) begin
                            s_d.regpool[c] = wdata[15:0];
                        end
                    end
                end
                default: ;
            endcase
        end
        // ------------------------------------------------------------
        // pin drive: programmable nibble enabled only when both its direction bits are set, or until the first direction write; bits 8 to 15 and 24 to 31 always
        // ------------------------------------------------------------
        for (int c = 0; c < 2; c++) begin
            for (int n = 0; n < 2; n++) begin
                for (int b = 0; b < 4; b++) begin
                    s_d.oe[c*16 + n*4 + b] = (s_q.dir[c][n*2 +: 2] == 2'h3) ||
                        s_q.fresh;
                    s_d.pins[c*16 + n*4 + b] = s_q.dir[c][n*2 +: 2] == 2'h3 ?
                        s_q.outv[c*16 + n*4 + b] : s_q.sync2[c*16 + n*4 + b];
                end
            end
            for (int b = 8; b < 16; b++) begin
                s_d.oe[c*16 + b] = 1'b1;
                s_d.pins[c*16 + b] = s_q.outv[c*16 + b];
            end
        end
        for (int c = 0; c < 2; c++) begin
            for (int b = 0; b < 16; b++) begin
                // polarity flips the driven level of the selected output only
                cfg_word[c*16 + b] = (op_idx[c] == 7'(b + 1 + c*16)) &&
                    !s_q.procsel[c][ppu_cfg_pkg::PS_OPOL_BIT];
            end
        end
        s_d.led = s_q.outv ^ cfg_word;
        s_d.drive = s_d.led & s_d.oe & {32{!s_q.fresh}};
        // ------------------------------------------------------------
        // register reads, one cycle later
        // ------------------------------------------------------------
        s_d.rdata = 32'h0;
        if (rd_stb) begin
            case (addr)
                ppu_cfg_pkg::ADDR_SELECT: s_d.rdata = {22'h0, s_q.dev, 3'h0, s_q.card};
                ppu_cfg_pkg::ADDR_INIT: begin
                    s_d.rdata = {21'h0, proc_count(s_q.mfnr[dev_sel[1]]),
                                 s_q.mfnr[dev_sel[1]]};
                end
                ppu_cfg_pkg::ADDR_PROCESS: s_d.rdata = dev_sel[1] ? s_q.procsel[1] :
                                                                    s_q.procsel[0];
                ppu_cfg_pkg::ADDR_PINSEL: s_d.rdata = {31'h0, s_q.run};
                ppu_cfg_pkg::ADDR_DIR: s_d.rdata = {20'h0, s_q.dir[1], 4'h0, s_q.dir[0]};
                ppu_cfg_pkg::ADDR_OUT: s_d.rdata = s_q.outv;
                ppu_cfg_pkg::ADDR_HIDDEN: s_d.rdata = {16'h0, s_q.hidden};
                ppu_cfg_pkg::ADDR_STATUS: s_d.rdata = {27'h0, s_q.slot_cnt[dev_sel[1]]};
                ppu_cfg_pkg::ADDR_PINS: s_d.rdata = s_q.pins;
                ppu_cfg_pkg::ADDR_REGPOOL: s_d.rdata = {s_q.regpool[1], s_q.regpool[0]};
                default: s_d.rdata = 32'h0;
            endcase
        end
        if (srst) begin
            s_d = '0;
            s_d.mfnr[0] = ppu_cfg_pkg::MFNR_RESET;
            s_d.mfnr[1] = ppu_cfg_pkg::MFNR_RESET;
            s_d.oe = '1;
            s_d.fresh = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        s_q <= s_d;
    end

    // outputs drive the output register level, with the selected output's polarity applied, where the pin is driven, low from reset until the first direction write
    assign chan_out = s_q.drive;
    assign chan_oe = s_q.oe;
    assign led_out = s_q.led;
    assign rdata = s_q.rdata;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_reset_drive: assert property (@(posedge ref_clk)
        $past(srst) |-> chan_oe == '1 && chan_out == '0)
        else $error("reset drive wrong");
    chk_fixed_outputs: assert property (@(posedge ref_clk) disable iff (srst)
        chan_oe[15:8] == 8'hff && chan_oe[31:24] == 8'hff)
        else $error("fixed outputs not driven");
    chk_process_stops: assert property (@(posedge ref_clk) disable iff (srst)
        wr_stb && addr == ppu_cfg_pkg::ADDR_PROCESS && dev_sel != 2'h0 |=> !s_q.run)
        else $error("run not stopped");
    chk_update_keeps: assert property (@(posedge ref_clk) disable iff (srst)
        wr_stb && addr == ppu_cfg_pkg::ADDR_UPDATE |=> s_q.run == $past(s_q.run))
        else $error("update stopped run");
    chk_read_latency: assert property (@(posedge ref_clk) disable iff (srst)
        rd_stb && addr == ppu_cfg_pkg::ADDR_OUT |=> rdata == $past(s_q.outv))
        else $error("read data wrong");
    chk_card_zero: assert property (@(posedge ref_clk) disable iff (srst)
        s_q.card == 5'h00 |-> dev_sel == 2'h0)
        else $error("card zero selected");
    chk_no_pass: assert property (@(posedge ref_clk) disable iff (srst)
        s_q.mfnr[0] == 6'h01 |-> !s_q.hit[0])
        else $error("process ran at one");
    chk_slow_sample: assert property (@(posedge ref_clk) disable iff (srst)
        s_q.hit != 2'h0 |=> s_q.hit == 2'h0)
        else $error("sampled too often");
    cov_run: cover property (@(posedge ref_clk) s_q.run && s_q.hit != 2'h0);
    cov_update: cover property (@(posedge ref_clk) wr_stb && addr == ppu_cfg_pkg::ADDR_UPDATE);
    cov_nibble: cover property (@(posedge ref_clk) s_q.dir[0] == 4'hf);
endmodule

// ===== testbench/field_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// field side of the connector channels
// ------------------------------------------------------------
module field_model (
    input wire logic [31:0] chan_out,
    input wire logic [31:0] chan_oe,
    input wire logic [31:0] field_val,
    input wire logic [31:0] field_en,
    output logic [31:0] chan_in
);
    // wire level from both parties; an undriven line falls to its pull-down
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (chan_oe[i]) begin
                chan_in[i] = chan_out[i];
            end else if (field_en[i]) begin
                chan_in[i] = field_val[i];
            end else begin
                chan_in[i] = 1'b0;
            end
        end
    end
endmodule

// ===== testbench/pulse_processor_pin_config_bench.sv
`timescale 1ns/100ps
module pulse_processor_pin_config_bench;
    // ------------------------------------------------------------
    // signals and notes
    // ------------------------------------------------------------
    typedef struct {
        bit is_pin;
        logic [31:0] mask;
        logic [31:0] val;
        logic [31:0] oe;
    } note_t;
    logic ref_clk, srst, wr_stb, rd_stb, rd_pend, look, look_pend;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, chan_in, chan_out, chan_oe, led_out, field_val, field_en, r;
    note_t notes[$];
    int bad_count, n_checks;
    byte cnt_tab[20] = '{16, 0, 1, 2, 3, 4, 4, 5, 6, 7, 8, 8, 9, 10, 11, 12, 12, 13, 14, 15};

    pulse_processor_pin_config #(.CARD_ID(5'h01)) pulse_processor_pin_config_inst (
        .ref_clk(ref_clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .chan_in(chan_in), .chan_out(chan_out),
        .chan_oe(chan_oe), .led_out(led_out)
    );
    field_model field_model_inst (
        .chan_out(chan_out), .chan_oe(chan_oe), .field_val(field_val),
        .field_en(field_en), .chan_in(chan_in)
    );

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        notes.push_back('{1'b0, m, e, 32'h0});
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
    endtask
    // pin levels are looked at one cycle after the request, like a read
    task automatic pchk(input logic [31:0] m, input logic [31:0] oe, input logic [31:0] v);
        notes.push_back('{1'b1, m, v, oe});
        @(posedge ref_clk);
        look <= 1'b1;
        @(posedge ref_clk);
        look <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // comparison
    // ------------------------------------------------------------
    task automatic cmp_read(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected read at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_pins(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected pins at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    always @(posedge ref_clk) begin
        rd_pend <= rd_stb;
        look_pend <= look;
    end
    always @(negedge ref_clk) begin : watch
        note_t n;
        if ((rd_pend === 1'b1) || (look_pend === 1'b1)) begin
            if (notes.size() == 0) begin
                bad_count++;
                $display("unexpected result at %0t got %h exp %h", $time, rdata, 32'h0);
            end else begin
                n = notes.pop_front();
                if (n.is_pin) begin
                    cmp_pins(chan_oe & n.mask, n.oe & n.mask);
                    cmp_pins(chan_out & n.oe & n.mask, n.val & n.oe & n.mask);
                end else begin
                    cmp_read(rdata & n.mask, n.val & n.mask);
                end
            end
        end
    end
    // ------------------------------------------------------------
    // closing
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        $display("watchdog expired at %0t", $time);
        complete_run();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        addr = 4'h0;
        wdata = 32'h0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        look = 1'b0;
        field_val = 32'h0;
        field_en = 32'h0;
        void'($urandom(12822));
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        // reset state: all enables up, channels low, processor stopped
        pchk(32'hffffffff, 32'hffffffff, 32'h0);
        wr(ppu_cfg_pkg::ADDR_SELECT, 32'h00000101);
        rd(ppu_cfg_pkg::ADDR_INIT, 32'h000007ff, 32'h00000400);
        rd(ppu_cfg_pkg::ADDR_PINSEL, 32'h00000001, 32'h0);
        $display("test reset done");
        // card zero leaves the function number untouched
        wr(ppu_cfg_pkg::ADDR_SELECT, 32'h00000100);
        wr(ppu_cfg_pkg::ADDR_INIT, 32'h00000005);
        wr(ppu_cfg_pkg::ADDR_SELECT, 32'h00000101);
        rd(ppu_cfg_pkg::ADDR_SELECT, 32'h000003ff, 32'h00000101);
        rd(ppu_cfg_pkg::ADDR_INIT, 32'h000007ff, 32'h00000400);
        $display("test card select done");
        // function numbers 0 to 32, lower controller
        for (int m = 0; m <= 32; m++) begin
            wr(ppu_cfg_pkg::ADDR_INIT, 32'(m));
            r = (m < 20) ? 32'(cnt_tab[m]) : 32'h10;
            rd(ppu_cfg_pkg::ADDR_INIT, 32'h000007ff, (r << 6) | 32'(m));
        end
        $display("test function table done");
        // upper controller holds its own value
        wr(ppu_cfg_pkg::ADDR_SELECT, 32'h00000201);
        wr(ppu_cfg_pkg::ADDR_INIT, 32'h00000014);
        rd(ppu_cfg_pkg::ADDR_INIT, 32'h000007ff, 32'h00000414);
        wr(ppu_cfg_pkg::ADDR_SELECT, 32'h00000101);
        rd(ppu_cfg_pkg::ADDR_INIT, 32'h000007ff, 32'h00000420);
        $display("test controllers done");
        // init stops a running processor
        wr(ppu_cfg_pkg::ADDR_PINSEL, 32'h00000001);
        rd(ppu_cfg_pkg::ADDR_PINSEL, 32'h00000001, 32'h00000001);
        wr(ppu_cfg_pkg::ADDR_INIT, 32'h00000003);
        rd(ppu_cfg_pkg::ADDR_PINSEL, 32'h00000001, 32'h0);
        $display("test init stop done");
        // update keeps the processor running, process setup stops it
        wr(ppu_cfg_pkg::ADDR_PINSEL, 32'h00000001);
        r = 32'($urandom) & 32'h0000ffff;
        wr(ppu_cfg_pkg::ADDR_UPDATE, r);
        rd(ppu_cfg_pkg::ADDR_PINSEL, 32'h00000001, 32'h00000001);
        rd(ppu_cfg_pkg::ADDR_REGPOOL, 32'h0000ffff, r);
        wr(ppu_cfg_pkg::ADDR_PROCESS, 32'h00000000);
        rd(ppu_cfg_pkg::ADDR_PINSEL, 32'h00000001, 32'h0);
        $display("test update done");
        // second nibble only partly output, so it must not drive
        wr(ppu_cfg_pkg::ADDR_DIR, 32'h00000f07);
        pchk(32'hffffffff, 32'hffffff0f, 32'h0);
        wr(ppu_cfg_pkg::ADDR_DIR, 32'h00000f0f);
        r = $urandom;
        wr(ppu_cfg_pkg::ADDR_OUT, r);
        pchk(32'hffffffff, 32'hffffffff, r);
        rd(ppu_cfg_pkg::ADDR_PINS, 32'hff00ff00, r);
        $display("test directions done");
        // all programmable nibbles back to input, field drives them
        wr(ppu_cfg_pkg::ADDR_DIR, 32'h0);
        field_val <= $urandom;
        field_en <= 32'h00ff00ff;
        repeat (4) @(posedge ref_clk);
        pchk(32'h00ff00ff, 32'h0, 32'h0);
        rd(ppu_cfg_pkg::ADDR_PINS, 32'h00ff00ff, field_val);
        rd(ppu_cfg_pkg::ADDR_PINS, 32'hff00ff00, r);
        $display("test inputs done");
        // hidden pins written and read back
        r = {16'h0, 16'($urandom)};
        wr(ppu_cfg_pkg::ADDR_HIDDEN, r);
        rd(ppu_cfg_pkg::ADDR_HIDDEN, 32'h0000ffff, r);
        $display("test hidden done");
        for (int i = 0; i < 10 && notes.size() != 0; i++) begin
            @(posedge ref_clk);
        end
        if (notes.size() != 0) begin
            bad_count++;
            $display("unexpected pending notes at %0t got %h exp %h", $time, notes.size(), 0);
        end
        complete_run();
    end
endmodule
